// ---- src/sysref_dly_cfg_pkg.sv ----
// Package of constants for the SYSREF delay-generator configuration registers.
// Operation
// - In-phase weight bits 15-9, resets to 7Fh.
// - Quadrature weight bits 6-0 of next register, reset 0.
// - Phase select bits 8-7 picks retimer clock phase.
// - Two-bit scale picks frequency range; 3 reserved.
// - Shared divider bits 11-9, reset 4h, divides clock.
// - Logic output has own weights and phase select.
`default_nettype none

package sysref_dly_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address on the bus is four times the index.
  localparam int          NUM_REGS       = 4;                   // Registers in the bank.
  localparam int          IDX_W          = 6;                   // Width of a word index.
  localparam int          ADDR_W         = 8;                   // Width of the byte address.
  localparam logic [5:0]  IDX_CH2I_CH1Q  = 6'h13;               // Channel 2 in-phase, channel 1 quad.
  localparam logic [5:0]  IDX_CH3I_CH2Q  = 6'h14;               // Channel 3 in-phase, channel 2 quad.
  localparam logic [5:0]  IDX_LOGI_CH3Q  = 6'h15;               // Logic in-phase, channel 3 quad.
  localparam logic [5:0]  IDX_SCALE_DIV  = 6'h16;               // Scales, divider, logic quad.
  localparam logic [5:0]  IDX_BASE       = IDX_CH2I_CH1Q;       // First index of the bank.

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [15:0] RST_WEIGHT_REG = 16'hFE00;            // In-phase 7Fh, phase 0, quad 0.
  localparam logic [15:0] RST_DIV_REG    = 16'h0800;            // Divider 4h, everything else 0.

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int          IW_MSB         = 15;                  // In-phase weight.
  localparam int          IW_LSB         = 9;
  localparam int          PH_MSB         = 8;                   // Retimer phase select.
  localparam int          PH_LSB         = 7;
  localparam int          QW_MSB         = 6;                   // Quadrature weight.
  localparam int          QW_LSB         = 0;
  localparam int          SC1_MSB        = 15;                  // Channel 1 frequency range.
  localparam int          SC1_LSB        = 14;
  localparam int          SC0_MSB        = 13;                  // Channel 0 frequency range.
  localparam int          SC0_LSB        = 12;
  localparam int          DIV_MSB        = 11;                  // Delay-generator clock divider.
  localparam int          DIV_LSB        = 9;

  ////////////////////////////////////////////////////////////////////////////////
  // Encodings.
  typedef enum logic [1:0] {
    PH_INV_INPHASE = 2'h0,                                      // Inverted in-phase clock.
    PH_INV_QUAD    = 2'h1,                                      // Inverted quadrature clock.
    PH_QUAD        = 2'h2,                                      // Quadrature clock.
    PH_INPHASE     = 2'h3                                       // In-phase clock.
  } phase_sel_t;

  typedef enum logic [1:0] {
    RANGE_400_800  = 2'h0,                                      // 400 to 800 MHz.
    RANGE_200_400  = 2'h1,                                      // 200 to 400 MHz.
    RANGE_150_200  = 2'h2,                                      // 150 to 200 MHz.
    RANGE_RESERVED = 2'h3                                       // Reserved.
  } freq_range_t;

  localparam logic [2:0]  DIV_ENC_1      = 3'h0;                // Divide by 1.
  localparam logic [2:0]  DIV_ENC_2      = 3'h1;                // Divide by 2.
  localparam logic [2:0]  DIV_ENC_4      = 3'h2;                // Divide by 4.
  localparam logic [2:0]  DIV_ENC_8      = 3'h4;                // Divide by 8.
  localparam logic [3:0]  RATIO_1        = 4'h1;                // Decoded ratio values.
  localparam logic [3:0]  RATIO_2        = 4'h2;
  localparam logic [3:0]  RATIO_4        = 4'h4;
  localparam logic [3:0]  RATIO_8        = 4'h8;
  localparam logic [3:0]  RATIO_NONE     = 4'h0;                // Reserved divider encoding.

endpackage : sysref_dly_cfg_pkg

`default_nettype wire

// ---- src/sysref_dly_cfg_word.sv ----
// One 16-bit configuration word with byte-lane writes and a reset value.
`default_nettype none

module sysref_dly_cfg_word #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // Clock and reset.
  input  wire  logic        i_ref_clk,
  input  wire  logic        i_rst,
  // Write port.
  input  wire  logic        i_wr_en,
  input  wire  logic [1:0]  i_byte_en,
  input  wire  logic [15:0] i_wr_data,
  // Stored value.
  output logic       [15:0] o_value
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic [15:0] value;                                         // Stored word.
  } word_state_t;

  word_state_t st_r;                                            // Registered state.
  word_state_t st_nxt;                                          // Next state.

  ////////////////////////////////////////////////////////////////////////////////
  // Each enabled byte lane takes the written byte; others hold their value.
  always_comb begin
    st_nxt = st_r;
    if (i_wr_en) begin
      if (i_byte_en[0]) begin
        st_nxt.value[7:0] = i_wr_data[7:0];
      end
      if (i_byte_en[1]) begin
        st_nxt.value[15:8] = i_wr_data[15:8];
      end
    end
  end

  // The word loads its reset value and otherwise registers the next state.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r.value <= RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_value = st_r.value;

endmodule : sysref_dly_cfg_word

`default_nettype wire

// ---- src/sysref_dly_cfg_regs.sv ----
// Avalon-MM register bank that configures the SYSREF delay generators.
`default_nettype none

module sysref_dly_cfg_regs (
  // Clock and reset.
  input  wire  logic        I_REF_CLK,
  input  wire  logic        I_RST,
  // Avalon-MM slave.
  input  wire  logic [7:0]  I_AVS_ADDRESS,
  input  wire  logic        I_AVS_READ,
  input  wire  logic        I_AVS_WRITE,
  input  wire  logic [31:0] I_AVS_WRITEDATA,
  input  wire  logic [3:0]  I_AVS_BYTEENABLE,
  output logic       [31:0] O_AVS_READDATA,
  output logic              O_AVS_WAITREQUEST,
  // Channel 1 settings.
  output logic       [6:0]  O_CHAN1_QUAD_WEIGHT,
  output logic       [1:0]  O_CHAN1_FREQ_RANGE,
  // Channel 0 settings.
  output logic       [1:0]  O_CHAN0_FREQ_RANGE,
  // Channel 2 settings.
  output logic       [6:0]  O_CHAN2_INPHASE_WEIGHT,
  output logic       [1:0]  O_CHAN2_RETIMER_PHASE_SEL,
  output logic       [6:0]  O_CHAN2_QUAD_WEIGHT,
  // Channel 3 settings.
  output logic       [6:0]  O_CHAN3_INPHASE_WEIGHT,
  output logic       [1:0]  O_CHAN3_RETIMER_PHASE_SEL,
  output logic       [6:0]  O_CHAN3_QUAD_WEIGHT,
  // Logic-clock SYSREF output settings.
  output logic       [6:0]  O_LOGIC_CHAN_INPHASE_WEIGHT,
  output logic       [1:0]  O_LOGIC_CHAN_RETIMER_PHASE_SEL,
  output logic       [6:0]  O_LOGIC_CHAN_QUAD_WEIGHT,
  // Shared delay-generator divider.
  output logic       [2:0]  O_DELAY_GEN_CLOCK_DIVIDER,
  output logic       [3:0]  O_DELAY_GEN_DIV_RATIO
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus state.
  typedef struct packed {
    logic        waitreq;                                       // High until a request is answered.
    logic [31:0] rd_data;                                       // Read data for the bus.
    logic [3:0]  div_ratio;                                     // Decoded divide ratio.
  } bus_state_t;

  bus_state_t  st_r;                                            // Registered state.
  bus_state_t  st_nxt;                                          // Next state.
  logic [5:0]  word_idx;                                        // Word index of the request.
  logic [15:0] reg_q [sysref_dly_cfg_pkg::NUM_REGS];            // Stored words.
  logic [15:0] rd_mux;                                          // Word selected for a read.
  logic [sysref_dly_cfg_pkg::NUM_REGS-1:0] hit;                 // Index match per word.
  logic [15:0] div_reg;                                         // Divider register shorthand.

  assign word_idx = I_AVS_ADDRESS[7:2];
  assign div_reg  = reg_q[3];

  ////////////////////////////////////////////////////////////////////////////////
  // One word per register; writes land at the edge that completes the transfer.
  for (genvar g = 0; g < sysref_dly_cfg_pkg::NUM_REGS; g++) begin : g_word
    localparam logic [15:0] RST_V = (g == sysref_dly_cfg_pkg::NUM_REGS - 1) ?
                                    sysref_dly_cfg_pkg::RST_DIV_REG :
                                    sysref_dly_cfg_pkg::RST_WEIGHT_REG;

    // The index decode compares against the bank base plus this word's offset.
    assign hit[g] = (word_idx == 6'(sysref_dly_cfg_pkg::IDX_BASE + 6'(g)));

    sysref_dly_cfg_word #(
      .RESET_VAL (RST_V)
    ) u_word (
      .i_ref_clk (I_REF_CLK),
      .i_rst     (I_RST),
      .i_wr_en   (I_AVS_WRITE && !st_r.waitreq && hit[g]),
      .i_byte_en (I_AVS_BYTEENABLE[1:0]),
      .i_wr_data (I_AVS_WRITEDATA[15:0]),
      .o_value   (reg_q[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; an unmapped index reads as zero.
  always_comb begin
    rd_mux = 16'h0000;
    if (hit[0]) begin
      rd_mux = reg_q[0];
    end else if (hit[1]) begin
      rd_mux = reg_q[1];
    end else if (hit[2]) begin
      rd_mux = reg_q[2];
    end else if (hit[3]) begin
      rd_mux = reg_q[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake and divider decode.
  always_comb begin
    st_nxt = st_r;
    if (st_r.waitreq) begin
      // A new request is answered one cycle after it is seen.
      if (I_AVS_READ || I_AVS_WRITE) begin
        st_nxt.waitreq = 1'b0;
        st_nxt.rd_data = I_AVS_READ ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
    end else begin
      // The answering cycle is over; raise waitrequest for the next request.
      st_nxt.waitreq = 1'b1;
    end
    // The divider field is turned into the ratio the interpolator clock sees.
    case (div_reg[sysref_dly_cfg_pkg::DIV_MSB:sysref_dly_cfg_pkg::DIV_LSB])
      sysref_dly_cfg_pkg::DIV_ENC_1: st_nxt.div_ratio = sysref_dly_cfg_pkg::RATIO_1;
      sysref_dly_cfg_pkg::DIV_ENC_2: st_nxt.div_ratio = sysref_dly_cfg_pkg::RATIO_2;
      sysref_dly_cfg_pkg::DIV_ENC_4: st_nxt.div_ratio = sysref_dly_cfg_pkg::RATIO_4;
      sysref_dly_cfg_pkg::DIV_ENC_8: st_nxt.div_ratio = sysref_dly_cfg_pkg::RATIO_8;
      default:                       st_nxt.div_ratio = sysref_dly_cfg_pkg::RATIO_NONE;
    endcase
  end

  // The bus state resets to waiting, zero read data and the reset ratio.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      st_r.waitreq   <= 1'b1;
      st_r.rd_data   <= 32'h0000_0000;
      st_r.div_ratio <= sysref_dly_cfg_pkg::RATIO_8;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken straight from a stored word or the bus state.
  assign O_AVS_READDATA     = st_r.rd_data;
  assign O_AVS_WAITREQUEST  = st_r.waitreq;
  assign O_DELAY_GEN_DIV_RATIO = st_r.div_ratio;

  // Quadrature weights sit in the low bits of the word after the in-phase weight.
  assign O_CHAN1_QUAD_WEIGHT = reg_q[0][sysref_dly_cfg_pkg::QW_MSB:sysref_dly_cfg_pkg::QW_LSB];
  assign O_CHAN2_QUAD_WEIGHT = reg_q[1][sysref_dly_cfg_pkg::QW_MSB:sysref_dly_cfg_pkg::QW_LSB];
  assign O_CHAN3_QUAD_WEIGHT = reg_q[2][sysref_dly_cfg_pkg::QW_MSB:sysref_dly_cfg_pkg::QW_LSB];

  // In-phase weights take the top seven bits.
  assign O_CHAN2_INPHASE_WEIGHT =
    reg_q[0][sysref_dly_cfg_pkg::IW_MSB:sysref_dly_cfg_pkg::IW_LSB];
  assign O_CHAN3_INPHASE_WEIGHT =
    reg_q[1][sysref_dly_cfg_pkg::IW_MSB:sysref_dly_cfg_pkg::IW_LSB];

  // Phase selects choose the retimer's interpolator clock phase.
  assign O_CHAN2_RETIMER_PHASE_SEL =
    reg_q[0][sysref_dly_cfg_pkg::PH_MSB:sysref_dly_cfg_pkg::PH_LSB];
  assign O_CHAN3_RETIMER_PHASE_SEL =
    reg_q[1][sysref_dly_cfg_pkg::PH_MSB:sysref_dly_cfg_pkg::PH_LSB];

  // The logic-clock output keeps its own weights and phase select.
  assign O_LOGIC_CHAN_INPHASE_WEIGHT =
    reg_q[2][sysref_dly_cfg_pkg::IW_MSB:sysref_dly_cfg_pkg::IW_LSB];
  assign O_LOGIC_CHAN_RETIMER_PHASE_SEL =
    reg_q[2][sysref_dly_cfg_pkg::PH_MSB:sysref_dly_cfg_pkg::PH_LSB];
  assign O_LOGIC_CHAN_QUAD_WEIGHT =
    div_reg[sysref_dly_cfg_pkg::QW_MSB:sysref_dly_cfg_pkg::QW_LSB];

  // Frequency ranges are passed on as stored; the reserved code is not altered.
  assign O_CHAN1_FREQ_RANGE = div_reg[sysref_dly_cfg_pkg::SC1_MSB:sysref_dly_cfg_pkg::SC1_LSB];
  assign O_CHAN0_FREQ_RANGE = div_reg[sysref_dly_cfg_pkg::SC0_MSB:sysref_dly_cfg_pkg::SC0_LSB];

  // The raw divider field.
  assign O_DELAY_GEN_CLOCK_DIVIDER =
    div_reg[sysref_dly_cfg_pkg::DIV_MSB:sysref_dly_cfg_pkg::DIV_LSB];

endmodule : sysref_dly_cfg_regs

`default_nettype wire

// ---- tb/sysref_dly_cfg_regs_assertions.sv ----
// Concurrent checks on the ports of the SYSREF delay-generator register bank.
`default_nettype none

module sysref_dly_cfg_regs_assertions (
  // Clock, reset and bus.
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST,
  input  wire logic [7:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  input  wire logic [31:0] O_AVS_READDATA,
  input  wire logic        O_AVS_WAITREQUEST,
  // Field outputs.
  input  wire logic [6:0]  O_CHAN1_QUAD_WEIGHT,
  input  wire logic [1:0]  O_CHAN1_FREQ_RANGE,
  input  wire logic [1:0]  O_CHAN0_FREQ_RANGE,
  input  wire logic [6:0]  O_CHAN2_INPHASE_WEIGHT,
  input  wire logic [1:0]  O_CHAN2_RETIMER_PHASE_SEL,
  input  wire logic [6:0]  O_CHAN2_QUAD_WEIGHT,
  input  wire logic [6:0]  O_LOGIC_CHAN_INPHASE_WEIGHT,
  input  wire logic [1:0]  O_LOGIC_CHAN_RETIMER_PHASE_SEL,
  input  wire logic [2:0]  O_DELAY_GEN_CLOCK_DIVIDER,
  input  wire logic [3:0]  O_DELAY_GEN_DIV_RATIO
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  logic       done_wr;     // A write completes at this edge.
  logic [3:0] ratio_want;  // Ratio that the current divider code decodes to.
  logic [2:0] dv;          // Short alias of the divider output.
  assign dv = O_DELAY_GEN_CLOCK_DIVIDER;
  assign done_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST;
  assign ratio_want = (dv == 3'h4) ? 4'h8 : (dv < 3'h3) ? 4'h1 << dv : 4'h0;
  ////////////////////////////////////////////////////////////////////////////////
  wait_one_a: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=>
    !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST) else $error("bus answer not one cycle");
  ch2_store_a: assert property (done_wr && I_AVS_ADDRESS == 8'h4C && I_AVS_BYTEENABLE[1:0] == 2'h3
    |=> {O_CHAN2_INPHASE_WEIGHT, O_CHAN2_RETIMER_PHASE_SEL} == $past(I_AVS_WRITEDATA[15:7]))
    else $error("channel 2 fields not stored");
  quad_store_a: assert property (done_wr && I_AVS_ADDRESS == 8'h50 && I_AVS_BYTEENABLE[0] |=>
    O_CHAN2_QUAD_WEIGHT == $past(I_AVS_WRITEDATA[6:0])) else $error("quad weight not stored");
  logic_store_a: assert property (done_wr && I_AVS_ADDRESS == 8'h54 && I_AVS_BYTEENABLE[1:0] == 2'h3
    |=> {O_LOGIC_CHAN_INPHASE_WEIGHT, O_LOGIC_CHAN_RETIMER_PHASE_SEL} == $past(I_AVS_WRITEDATA[15:7]))
    else $error("logic fields not stored");
  range_store_a: assert property (done_wr && I_AVS_ADDRESS == 8'h58 && I_AVS_BYTEENABLE[1] |=>
    {O_CHAN1_FREQ_RANGE, O_CHAN0_FREQ_RANGE} == $past(I_AVS_WRITEDATA[15:12]))
    else $error("ranges not stored");
  ratio_map_a: assert property (1'b1 |=> O_DELAY_GEN_DIV_RATIO == $past(ratio_want))
    else $error("divider ratio wrong");
  field_hold_a: assert property (!done_wr |=>
    $stable({O_CHAN2_QUAD_WEIGHT, dv, O_CHAN1_QUAD_WEIGHT})) else $error("field moved");
  read_back_a: assert property (I_AVS_READ && O_AVS_WAITREQUEST && I_AVS_ADDRESS == 8'h4C |=>
    O_AVS_READDATA == {16'h0000, $past(O_CHAN2_INPHASE_WEIGHT),
    $past(O_CHAN2_RETIMER_PHASE_SEL), $past(O_CHAN1_QUAD_WEIGHT)}) else $error("readback wrong");
  wr_c: cover property (done_wr);
  rd_c: cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
  div1_c: cover property (O_DELAY_GEN_DIV_RATIO == 4'h1);
endmodule // sysref_dly_cfg_regs_assertions

bind sysref_dly_cfg_regs sysref_dly_cfg_regs_assertions chk (.*);

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the SYSREF delay-generator configuration registers.
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", n, e, a); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;                                   // 50 MHz clock.
  logic        rst = 1'b1;                                   // Synchronous reset.
  logic [7:0]  addr = 8'h00;                                 // Bus request fields.
  logic        rd = 1'b0, wr = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  be = 4'h0;
  logic        wait_req;
  logic [6:0]  c1q, c2i, c2q, c3i, c3q, li, lq;              // Field outputs.
  logic [1:0]  c1r, c0r, c2p, c3p, lp;
  logic [2:0]  div;
  logic [3:0]  ratio;
  int          mismatches = 0, comparisons = 0, cycles = 0;
  sysref_dly_cfg_regs uut (
    .I_REF_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wait_req), .O_CHAN1_QUAD_WEIGHT(c1q), .O_CHAN1_FREQ_RANGE(c1r),
    .O_CHAN0_FREQ_RANGE(c0r), .O_CHAN2_INPHASE_WEIGHT(c2i), .O_CHAN2_RETIMER_PHASE_SEL(c2p),
    .O_CHAN2_QUAD_WEIGHT(c2q), .O_CHAN3_INPHASE_WEIGHT(c3i), .O_CHAN3_RETIMER_PHASE_SEL(c3p),
    .O_CHAN3_QUAD_WEIGHT(c3q), .O_LOGIC_CHAN_INPHASE_WEIGHT(li),
    .O_LOGIC_CHAN_RETIMER_PHASE_SEL(lp), .O_LOGIC_CHAN_QUAD_WEIGHT(lq),
    .O_DELAY_GEN_CLOCK_DIVIDER(div), .O_DELAY_GEN_DIV_RATIO(ratio));
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks hold the request until waitrequest is seen low at a rising edge.
  task automatic bus_write(input logic [7:0] a, input logic [15:0] d, input logic [3:0] b);
    @(posedge clk);
    addr  <= a;
    wdata <= {16'h0000, d};
    be    <= b;
    wr    <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    wr <= 1'b0;
  endtask
  task automatic read_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    `CHK("readback", {16'h0000, e}, rdata)
    rd <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    @(negedge clk);
    `CHK("ratio", 4'h8, ratio)
    `CHK("chan2 inphase", 7'h7F, c2i)
    read_chk(8'h4C, 16'hFE00);
    read_chk(8'h50, 16'hFE00);
    read_chk(8'h54, 16'hFE00);
    read_chk(8'h58, 16'h0800);
    $display("test_reset done");
  endtask
  // Every phase code on three channels; each channel's weights sum to 127 once programmed.
  task automatic test_fields();
    logic [15:0] w;
    for (int p = 0; p < 4; p++) begin
      w = {7'(7'h70 + p), 2'(p), 7'(7'h2A + p)};
      bus_write(8'h4C, w, 4'h3);
      bus_write(8'h50, {7'(7'h30 + p), 2'(3 - p), 7'(7'h0F - p)}, 4'hF);
      bus_write(8'h54, {7'(7'h20 + p), 2'(p ^ 1), 7'(7'h4F - p)}, 4'hF);
      bus_write(8'h58, {9'h000, 7'(7'h5F - p)}, 4'h1);
      repeat (2) @(negedge clk);
      `CHK("chan2 phase", 2'(p), c2p)
      `CHK("chan2 inphase", 7'(7'h70 + p), c2i)
      `CHK("chan1 quad", 7'(7'h2A + p), c1q)
      `CHK("chan2 quad", 7'(7'h0F - p), c2q)
      `CHK("chan3 inphase", 7'(7'h30 + p), c3i)
      `CHK("chan3 phase", 2'(3 - p), c3p)
      `CHK("chan3 quad", 7'(7'h4F - p), c3q)
      `CHK("logic phase", 2'(p ^ 1), lp)
      `CHK("logic inphase", 7'(7'h20 + p), li)
      `CHK("logic quad", 7'(7'h5F - p), lq)
      `CHK("divider kept", 3'h4, div)
      read_chk(8'h4C, w);
    end
    $display("test_fields done");
  endtask
  // Every listed divider code and every permitted range code; logic weights kept at 127.
  task automatic test_divider();
    logic [2:0]  enc [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h1};
    logic [3:0]  rat [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h2};
    logic [15:0] d;
    for (int k = 0; k < 5; k++) begin
      d = {2'(k % 3), 2'(2 - k % 3), enc[k], 2'h0, 7'(7'h6F - k)};
      bus_write(8'h54, {7'(7'h10 + k), 2'h0, 7'h4C}, 4'h3);
      bus_write(8'h58, d, 4'h3);
      repeat (2) @(negedge clk);
      `CHK("divider", enc[k], div)
      `CHK("ratio", rat[k], ratio)
      `CHK("chan1 range", 2'(k % 3), c1r)
      `CHK("chan0 range", 2'(2 - k % 3), c0r)
      `CHK("logic quad", 7'(7'h6F - k), lq)
      `CHK("logic inphase", 7'(7'h10 + k), li)
      read_chk(8'h58, d);
    end
    $display("test_divider done");
  endtask
  // Byte lanes, ignored upper lanes, unmapped words and a reset in mid-run.
  task automatic test_lanes();
    bus_write(8'h50, 16'h1234, 4'hF);
    bus_write(8'h50, 16'hABCD, 4'h1);
    read_chk(8'h50, 16'h12CD);
    bus_write(8'h50, 16'h5600, 4'h2);
    bus_write(8'h50, 16'hFFFF, 4'hC);
    read_chk(8'h50, 16'h56CD);
    bus_write(8'h5C, 16'hFFFF, 4'hF);
    read_chk(8'h5C, 16'h0000);
    read_chk(8'h48, 16'h0000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    read_chk(8'h50, 16'hFE00);
    $display("test_lanes done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the fewer than two hundred cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_fields();
    test_divider();
    test_lanes();
    final_report();
  end
endmodule // testbench

`default_nettype wire
